// ==== rtl/eeprom_link_consts.svh ====
// constants for the two-wire eeprom read and polling target
`ifndef EEPROM_LINK_CONSTS_SVH
`define EEPROM_LINK_CONSTS_SVH

`define DEV_PREFIX                 4'hA
`define DEV_PREFIX_MSB             7
`define DEV_PREFIX_LSB             4
`define BLOCK_MSB                  3
`define BLOCK_LSB                  1
`define RW_BIT                     0
`define ADDR_W                     11
`define MEM_DEPTH                  2048
`define ADDR_RST                   11'h000
`define BYTE_LAST_BIT              3'h7
`define CLK_PERIOD_NS              25
`define POWER_UP_COMMAND_DELAY_NS  100000
`define POWER_UP_COMMAND_CYCLES    ((`POWER_UP_COMMAND_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== rtl/eeprom_link_pkg.sv ====
// types shared by the eeprom read and polling target
`include "eeprom_link_consts.svh"
package eeprom_link_pkg;
  typedef logic [`ADDR_W-1:0] mem_addr_t;
  typedef logic [7:0]         byte_t;
  typedef logic [2:0]         bit_cnt_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV_ADDR, ST_DEV_ACK, ST_WORD_ADDR, ST_WORD_ACK,
    ST_WR_DATA, ST_WR_ACK, ST_RD_DATA, ST_RD_ACK
  } link_state_e;
endpackage : eeprom_link_pkg

// ==== rtl/mem_port_if.sv ====
// array port bundle between the link logic and the storage array
`timescale 1ns/1ps
interface mem_port_if;
  import eeprom_link_pkg::*;
  mem_addr_t rd_addr;
  byte_t     rd_data;
  logic      wr_en;
  mem_addr_t wr_addr;
  byte_t     wr_data;
  modport array (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
  modport user  (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
endinterface : mem_port_if

// ==== rtl/eeprom_array.sv ====
// storage array: loaded on the system clock, read on the link clock
`timescale 1ns/1ps
module eeprom_array
  import eeprom_link_pkg::*;
(
  input  wire logic  i_wr_clk,
  input  wire logic  i_rd_clk,
  mem_port_if.array  bus
);

  byte_t mem_q [`MEM_DEPTH];

  // load port for array contents
  always_ff @(posedge i_wr_clk) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_addr] <= bus.wr_data;
    end
  end

  // registered read data, follows the counter one link edge later
  always_ff @(posedge i_rd_clk) begin
    bus.rd_data <= mem_q[bus.rd_addr];
  end

endmodule : eeprom_array

// ==== rtl/serial_eeprom_read_and_poll.sv ====
// two-wire eeprom target: acknowledge polling and the three read modes
`timescale 1ns/1ps
`include "eeprom_link_consts.svh"
module serial_eeprom_read_and_poll
  import eeprom_link_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst_b,
  input  wire logic      i_scl,
  input  wire logic      i_sda_i,
  output logic           o_sda_o,
  output logic           o_sda_oe,
  input  wire logic      i_prog_busy,
  input  wire logic      i_load_en,
  input  wire mem_addr_t i_load_addr,
  input  wire byte_t     i_load_data,
  output logic           o_cmd_ready,
  output logic           o_link_active
);

  ////////////////////////////////////////////////////////////////////////////
  // system clock side: power-up hold-off and link activity
  logic [11:0] pu_cnt_q;
  logic        cmd_ready_q;
  logic        act_m_q;
  logic        act_s1_q;
  logic        act_s2_q;
  logic        link_active_q;
  logic        link_busy_q;
  wire         pu_done = (pu_cnt_q == 12'(`POWER_UP_COMMAND_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pu_cnt_q    <= 12'h000;
      cmd_ready_q <= 1'b0;
    end else if (!cmd_ready_q) begin
      pu_cnt_q    <= pu_cnt_q + 12'h001;
      cmd_ready_q <= pu_done;
    end
  end

  // three-stage sync of link activity, taken once two stages agree
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      act_m_q       <= 1'b0;
      act_s1_q      <= 1'b0;
      act_s2_q      <= 1'b0;
      link_active_q <= 1'b0;
    end else begin
      act_m_q  <= link_busy_q;
      act_s1_q <= act_m_q;
      act_s2_q <= act_s1_q;
      if (act_s1_q == act_s2_q) begin
        link_active_q <= act_s2_q;
      end
    end
  end

  assign o_cmd_ready   = cmd_ready_q;
  assign o_link_active = link_active_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus condition detect, clocked by the data line itself
  logic start_tog_q;
  logic stop_tog_q;
  logic start_seen_q;
  logic stop_seen_q;

  // falling data with clock high is a start
  always_ff @(negedge i_sda_i or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_tog_q <= 1'b0;
    end else if (i_scl) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  // rising data with clock high is a stop
  always_ff @(posedge i_sda_i or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_tog_q <= 1'b0;
    end else if (i_scl) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link clock side: synchronisers and protocol engine
  logic        busy_m_q;
  logic        busy_s1_q;
  logic        busy_s2_q;
  logic        busy_s_q;
  logic        rdy_m_q;
  logic        rdy_s1_q;
  logic        rdy_s2_q;
  logic        rdy_s_q;
  link_state_e st_q;
  link_state_e st_d;
  bit_cnt_t    cnt_q;
  bit_cnt_t    cnt_d;
  byte_t       sh_q;
  byte_t       tx_q;
  byte_t       tx_d;
  mem_addr_t   addr_q;
  mem_addr_t   addr_d;
  logic        rw_q;
  logic        rw_d;
  logic [2:0]  blk_q;
  logic [2:0]  blk_d;
  logic        oe_q;
  logic        sda_o_q;
  mem_port_if  mem_bus ();

  // decode of the byte being completed and the bus events
  wire byte_t rx_byte   = {sh_q[6:0], i_sda_i};
  wire        start_ev  = start_tog_q ^ start_seen_q;
  wire        stop_ev   = stop_tog_q ^ stop_seen_q;
  wire        last_bit  = (cnt_q == `BYTE_LAST_BIT);
  wire        prefix_ok = (rx_byte[`DEV_PREFIX_MSB:`DEV_PREFIX_LSB] == `DEV_PREFIX);
  wire        accept    = rdy_s_q && !busy_s_q;
  wire        tx_bit    = tx_q[`BYTE_LAST_BIT - cnt_q];
  wire        ack_slot  = (st_q == ST_DEV_ACK) || (st_q == ST_WORD_ACK) || (st_q == ST_WR_ACK);
  wire        oe_d      = ack_slot || ((st_q == ST_RD_DATA) && !tx_bit);

  // three-stage level syncs into the link clock, taken once two stages agree
  always_ff @(posedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_m_q  <= 1'b1;
      busy_s1_q <= 1'b1;
      busy_s2_q <= 1'b1;
      busy_s_q  <= 1'b1;
      rdy_m_q   <= 1'b0;
      rdy_s1_q  <= 1'b0;
      rdy_s2_q  <= 1'b0;
      rdy_s_q   <= 1'b0;
    end else begin
      busy_m_q  <= i_prog_busy;
      busy_s1_q <= busy_m_q;
      busy_s2_q <= busy_s1_q;
      rdy_m_q   <= cmd_ready_q;
      rdy_s1_q  <= rdy_m_q;
      rdy_s2_q  <= rdy_s1_q;
      if (busy_s1_q == busy_s2_q) begin
        busy_s_q <= busy_s2_q;
      end
      if (rdy_s1_q == rdy_s2_q) begin
        rdy_s_q <= rdy_s2_q;
      end
    end
  end

  // protocol next state
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q + 3'h1;
    tx_d   = tx_q;
    addr_d = addr_q;
    rw_d   = rw_q;
    blk_d  = blk_q;
    if (start_ev) begin
      // a start drops any pending write
      st_d  = ST_DEV_ADDR;
      cnt_d = 3'h1;
    end else if (stop_ev) begin
      st_d = ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          cnt_d = 3'h0;
        end
        ST_DEV_ADDR: begin
          if (last_bit) begin
            st_d  = (prefix_ok && accept) ? ST_DEV_ACK : ST_IDLE;
            rw_d  = rx_byte[`RW_BIT];
            blk_d = rx_byte[`BLOCK_MSB:`BLOCK_LSB];
          end
        end
        ST_DEV_ACK: begin
          cnt_d = 3'h0;
          if (rw_q) begin
            // load byte and step the counter
            st_d   = ST_RD_DATA;
            tx_d   = mem_bus.rd_data;
            addr_d = addr_q + `ADDR_W'(1);
          end else begin
            st_d = ST_WORD_ADDR;
          end
        end
        ST_WORD_ADDR: begin
          if (last_bit) begin
            st_d   = ST_WORD_ACK;
            addr_d = {blk_q, rx_byte};
          end
        end
        ST_WORD_ACK, ST_WR_ACK: begin
          st_d  = ST_WR_DATA;
          cnt_d = 3'h0;
        end
        ST_WR_DATA: begin
          if (last_bit) begin
            st_d = ST_WR_ACK;
          end
        end
        ST_RD_DATA: begin
          if (last_bit) begin
            st_d = ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          cnt_d = 3'h0;
          if (!i_sda_i) begin
            st_d   = ST_RD_DATA;
            tx_d   = mem_bus.rd_data;
            addr_d = addr_q + `ADDR_W'(1);
          end else begin
            st_d = ST_IDLE;
          end
        end
      endcase
    end
  end

  // protocol state, sampled on rising link clock
  always_ff @(posedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q         <= ST_IDLE;
      cnt_q        <= 3'h0;
      sh_q         <= 8'h00;
      tx_q         <= 8'h00;
      rw_q         <= 1'b0;
      blk_q        <= 3'h0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
    end else begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      sh_q         <= rx_byte;
      tx_q         <= tx_d;
      rw_q         <= rw_d;
      blk_q        <= blk_d;
      start_seen_q <= start_tog_q;
      stop_seen_q  <= stop_tog_q;
    end
  end

  always_ff @(posedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_q <= `ADDR_RST;
    end else begin
      addr_q <= addr_d;
    end
  end

  // data line drive on falling link clock
  always_ff @(negedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      oe_q        <= 1'b0;
      sda_o_q     <= 1'b0;
      link_busy_q <= 1'b0;
    end else begin
      oe_q        <= oe_d;
      sda_o_q     <= 1'b0;
      link_busy_q <= (st_q != ST_IDLE);
    end
  end

  assign o_sda_oe = oe_q;
  assign o_sda_o  = sda_o_q;

  ////////////////////////////////////////////////////////////////////////////
  // storage array
  assign mem_bus.rd_addr = addr_q;
  assign mem_bus.wr_en   = i_load_en;
  assign mem_bus.wr_addr = i_load_addr;
  assign mem_bus.wr_data = i_load_data;

  eeprom_array u_array (
    .i_wr_clk (i_clk),
    .i_rd_clk (i_scl),
    .bus      (mem_bus.array)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  wire quiet = !start_ev && !stop_ev;

  property p_poll_nack;
    @(posedge i_scl) disable iff (!i_rst_b)
      (st_q == ST_DEV_ADDR && last_bit && busy_s_q && quiet) |=> (st_q == ST_IDLE) ##0 !o_sda_oe;
  endproperty
  a_poll_nack: assert property (p_poll_nack) else $error("address acked while busy");

  property p_poll_ack;
    @(posedge i_scl) disable iff (!i_rst_b)
      (st_q == ST_DEV_ADDR && last_bit && accept && prefix_ok && quiet) |=> (st_q == ST_DEV_ACK);
  endproperty
  a_poll_ack: assert property (p_poll_ack) else $error("valid address not acked");

  property p_rw_select;
    @(posedge i_scl) disable iff (!i_rst_b)
      (st_q == ST_DEV_ACK && quiet) |=> (st_q == (rw_q ? ST_RD_DATA : ST_WORD_ADDR));
  endproperty
  a_rw_select: assert property (p_rw_select) else $error("wrong direction after address");

  property p_read_step;
    @(posedge i_scl) disable iff (!i_rst_b)
      (st_q == ST_DEV_ACK && rw_q && quiet) |=> (addr_q == $past(addr_q) + `ADDR_W'(1)) ##0 (tx_q == $past(mem_bus.rd_data));
  endproperty
  a_read_step: assert property (p_read_step) else $error("read byte or counter step wrong");

  property p_seq_next;
    @(posedge i_scl) disable iff (!i_rst_b)
      (st_q == ST_RD_ACK && !i_sda_i && quiet) |=> (st_q == ST_RD_DATA) ##0 (cnt_q == 3'h0);
  endproperty
  a_seq_next: assert property (p_seq_next) else $error("ack did not start next byte");

  property p_wrap;
    @(posedge i_scl) disable iff (!i_rst_b)
      (st_q == ST_RD_ACK && !i_sda_i && quiet && addr_q == 11'h7FF) |=> (addr_q == 11'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_start_restart;
    @(posedge i_scl) disable iff (!i_rst_b)
      start_ev |=> (st_q == ST_DEV_ADDR) ##0 (cnt_q == 3'h1);
  endproperty
  a_start_restart: assert property (p_start_restart) else $error("start not honoured");

  property p_prefix;
    @(posedge i_scl) disable iff (!i_rst_b)
      (st_q == ST_DEV_ADDR && last_bit && !prefix_ok && quiet) |=> (st_q == ST_IDLE);
  endproperty
  a_prefix: assert property (p_prefix) else $error("foreign address answered");

  property p_ack_drive;
    @(posedge i_scl) disable iff (!i_rst_b)
      ack_slot |-> o_sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

  property p_release;
    @(posedge i_scl) disable iff (!i_rst_b)
      (st_q == ST_RD_ACK || st_q == ST_IDLE) |-> !o_sda_oe && !o_sda_o;
  endproperty
  a_release: assert property (p_release) else $error("line held in release phase");

  property p_holdoff;
    @(posedge i_clk) disable iff (!i_rst_b)
      $rose(cmd_ready_q) |-> ($past(pu_cnt_q) == 12'(`POWER_UP_COMMAND_CYCLES - 1));
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("hold-off length wrong");

  property p_c_read;
    @(posedge i_scl) disable iff (!i_rst_b) (st_q == ST_RD_ACK && i_sda_i);
  endproperty
  c_read: cover property (p_c_read);

  property p_c_seq;
    @(posedge i_scl) disable iff (!i_rst_b) (st_q == ST_RD_ACK && !i_sda_i);
  endproperty
  c_seq: cover property (p_c_seq);

  property p_c_poll_nack;
    @(posedge i_scl) disable iff (!i_rst_b) (st_q == ST_DEV_ADDR && last_bit && prefix_ok && busy_s_q);
  endproperty
  c_poll_nack: cover property (p_c_poll_nack);

  property p_c_random;
    @(posedge i_scl) disable iff (!i_rst_b) (st_q == ST_WR_DATA && start_ev);
  endproperty
  c_random: cover property (p_c_random);

endmodule : serial_eeprom_read_and_poll

// ==== test/two_wire_master_model.sv ====
// two-wire bus master model: drives clock and data, samples the resolved data line
`timescale 1ns/1ps
module two_wire_master_model (
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  localparam int HALF_NS = 15;
  localparam int FREE_NS = 1300;
  ////////////////////////////////////////////////////////////////////////////////
  // bus idles high: clock stands still between frames, data left to the pull-up
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // start is data falling with clock high
  task automatic start();
    o_sda = 1'h1;
    #(HALF_NS);
    o_scl = 1'h1;
    #(HALF_NS);
    o_sda = 1'h0;
    #(HALF_NS);
    o_scl = 1'h0;
  endtask : start
  // data moves only while the clock is low, sampled just before the fall
  task automatic clk_bit(input logic b, output logic s);
    #5;
    o_sda = b;
    #(HALF_NS - 5);
    o_scl = 1'h1;
    #(HALF_NS - 1);
    s = i_sda;
    #1;
    o_scl = 1'h0;
  endtask : clk_bit
  // msb first, then the ninth clock returns the target's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'h1, s);
    ack = ~s;
  endtask : send_byte
  // acknowledge asks for one more byte, a released slot ends the read
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'h1, s);
      d[i] = s;
    end
    clk_bit(~more, s);
  endtask : recv_byte
  // stop is data rising with clock high, then the bus stays free
  task automatic stop();
    #5;
    o_sda = 1'h0;
    #(HALF_NS - 5);
    o_scl = 1'h1;
    #(HALF_NS);
    o_sda = 1'h1;
    #(FREE_NS);
  endtask : stop
endmodule : two_wire_master_model

// ==== test/serial_eeprom_read_and_poll_bench.sv ====
// self-checking bench for the two-wire eeprom read and polling target
`timescale 1ns/1ps
`include "eeprom_link_consts.svh"
module serial_eeprom_read_and_poll_bench;
  import eeprom_link_pkg::*;
  logic        i_clk;
  logic        i_rst_b;
  logic        scl;
  logic        m_sda;
  logic        sda_o;
  logic        sda_oe;
  logic        prog_busy;
  logic        load_en;
  mem_addr_t   load_addr;
  byte_t       load_data;
  logic        cmd_ready;
  logic        link_active;
  wire logic   sda_w;
  byte_t       mem_m [`MEM_DEPTH];
  logic [31:0] rng_q;
  int          failures;
  int          num_checks;
  ////////////////////////////////////////////////////////////////////////////////
  // open-drain line: pulled up unless some party pulls it low
  assign sda_w = m_sda & ~(sda_oe & ~sda_o);
  // system clock, 25 ns period
  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  serial_eeprom_read_and_poll dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda_i(sda_w), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_prog_busy(prog_busy), .i_load_en(load_en), .i_load_addr(load_addr), .i_load_data(load_data),
    .o_cmd_ready(cmd_ready), .o_link_active(link_active));
  two_wire_master_model master_u (.o_scl(scl), .o_sda(m_sda), .i_sda(sda_w));
  ////////////////////////////////////////////////////////////////////////////////
  // repeatable pseudo-random source
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction : xorshift
  // expected byte at an array location, from the bench's own copy
  function automatic byte_t exp_byte(input mem_addr_t a);
    return mem_m[a];
  endfunction : exp_byte
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // dummy write loads the 11-bit address from block bits and word byte
  task automatic set_addr(input mem_addr_t a);
    logic ack;
    master_u.start();
    master_u.send_byte({`DEV_PREFIX, a[10:8], 1'h0}, ack);
    check("dummy write ack", ack, 1'h1);
    master_u.send_byte(a[7:0], ack);
    check("word addr ack", ack, 1'h1);
  endtask : set_addr
  // read-type address, n bytes from the counter, master ends the read
  task automatic read_run(input mem_addr_t a, input int n);
    logic      ack;
    byte_t     d;
    mem_addr_t p;
    p = a;
    rng_q = xorshift(rng_q);
    master_u.start();
    master_u.send_byte({`DEV_PREFIX, rng_q[2:0], 1'h1}, ack);
    check("read addr ack", ack, 1'h1);
    check("link busy", link_active, 1'h1);
    for (int i = 0; i < n; i++) begin
      master_u.recv_byte(i < n - 1, d);
      check("read byte", d, exp_byte(p));
      p = p + 11'h001;
    end
    master_u.stop();
    repeat (8) @(posedge i_clk);
    check("link idle", link_active, 1'h0);
    check("sda released", sda_oe, 1'h0);
  endtask : read_run
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : main_seq
    logic      ack;
    mem_addr_t a;
    realtime   t0;
    int        n;
    i_rst_b = 1'h0;
    prog_busy = 1'h0;
    load_en = 1'h0;
    load_addr = 11'h000;
    load_data = 8'h00;
    failures = 0;
    num_checks = 0;
    rng_q = 32'h0000_0062;
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_b = 1'h1;
    t0 = $realtime;
    check("ready at release", cmd_ready, 1'h0);
    master_u.start();
    master_u.send_byte({`DEV_PREFIX, 4'h1}, ack);
    check("early ack", ack, 1'h0);
    master_u.stop();
    // fill the array and the bench copy with random bytes
    for (int i = 0; i < `MEM_DEPTH; i++) begin
      @(negedge i_clk);
      rng_q = xorshift(rng_q);
      load_en = 1'h1;
      load_addr = mem_addr_t'(i);
      load_data = rng_q[7:0];
      mem_m[i] = rng_q[7:0];
    end
    @(negedge i_clk);
    load_en = 1'h0;
    // no command before the hold-off has run out
    n = 0;
    while (cmd_ready !== 1'h1 && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    n = int'(($realtime - t0) / 25.0);
    check("ready delay", 16'(n >= 4000 && n <= 4002), 1'h1);
    $display("test power_up_hold done");
    for (int p = 0; p < 16; p++) begin
      master_u.start();
      master_u.send_byte({p[3:0], 4'h0}, ack);
      check("prefix ack", ack, 16'(p[3:0] == `DEV_PREFIX));
      master_u.stop();
    end
    $display("test prefix done");
    for (int k = 0; k < 3; k++) begin
      @(negedge i_clk);
      prog_busy = (k < 2);
      master_u.start();
      master_u.send_byte({`DEV_PREFIX, 3'h0, k[0]}, ack);
      check("poll ack", ack, 16'(k == 2));
      master_u.stop();
    end
    $display("test polling done");
    for (int k = 0; k < 6; k++) begin
      rng_q = xorshift(rng_q);
      a = rng_q[10:0];
      set_addr(a);
      read_run(a, 1);
      read_run(a + 11'h001, 1);
    end
    $display("test random_and_current done");
    set_addr(11'h7FD);
    read_run(11'h7FD, 5);
    rng_q = xorshift(rng_q);
    a = rng_q[10:0];
    set_addr(a);
    read_run(a, 2 + int'(rng_q[13:12]));
    $display("test sequential_wrap done");
    summarize();
  end
  // watchdog: hold-off, fill and frames need about 6700 cycles
  initial begin : watchdog
    repeat (40000) @(posedge i_clk);
    failures++;
    $display("FAIL watchdog expected finish seen timeout");
    summarize();
  end
endmodule : serial_eeprom_read_and_poll_bench
